//--- rtl/average_value_ctrl.sv
// converter launch, averaging and min/max result logic
`include "average_value_map.svh"
`default_nettype none

module average_value_ctrl (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            conv_start,
	output logic      [4:0] chan_route,
	input  wire logic       conv_done,
	input  wire logic [7:0] conv_data
);

	average_value_pkg::average_value_state_t state_r, state_nxt;
	logic        launch_r,  launch_nxt;
	logic [5:0]  config_r,  config_nxt;
	logic [7:0]  avg_r,     avg_nxt;
	logic [7:0]  min_r,     min_nxt;
	logic [7:0]  max_r,     max_nxt;
	logic [7:0]  run_min_r, run_min_nxt;
	logic [7:0]  run_max_r, run_max_nxt;
	logic [14:0] sum_r,     sum_nxt;
	logic [7:0]  left_r,    left_nxt;
	logic [2:0]  size_r,    size_nxt;
	logic        start_r,   start_nxt;
	logic [4:0]  route_r,   route_nxt;
	logic [7:0]  rdata_r,   rdata_nxt;
	logic [2:0]  size_cfg;
	logic [2:0]  chan_cfg;
	logic        config_wr;
	logic        launch_go;
	logic        sample_in;
	logic        burst_end;

	// one-hot route of a channel code, reserved codes route nowhere
	function automatic logic [4:0] chan_decode(input logic [2:0] code);
		case (code)
			average_value_pkg::AVERAGE_VALUE_CH_HAPTIC:  chan_decode = 5'h01;
			average_value_pkg::AVERAGE_VALUE_CH_MONITOR: chan_decode = 5'h02;
			average_value_pkg::AVERAGE_VALUE_CH_CHARGER: chan_decode = 5'h04;
			average_value_pkg::AVERAGE_VALUE_CH_PUMP:    chan_decode = 5'h08;
			average_value_pkg::AVERAGE_VALUE_CH_BOOST:   chan_decode = 5'h10;
			default:                       chan_decode = 5'h00;
		endcase
	endfunction : chan_decode

	// samples still to come after the first one, for a size code
	function automatic logic [7:0] burst_last(input logic [2:0] size);
		burst_last = 8'(9'h001 << size) - 8'h01;
	endfunction : burst_last

	// config fields and request decode shared by the groups below
	assign size_cfg  = config_r[`AVERAGE_VALUE_SIZE_MSB:`AVERAGE_VALUE_SIZE_LSB];
	assign chan_cfg  = config_r[`AVERAGE_VALUE_CHAN_MSB:`AVERAGE_VALUE_CHAN_LSB];
	// config held steady during a burst so the count and divide agree
	assign config_wr = reg_wr && (reg_addr == `AVERAGE_VALUE_OFS_CONFIG)
	                   && (state_r == average_value_pkg::AVERAGE_VALUE_IDLE);
	assign launch_go = reg_wr && (reg_addr == `AVERAGE_VALUE_OFS_LAUNCH)
	                   && reg_wdata[`AVERAGE_VALUE_LAUNCH_BIT]
	                   && (state_r == average_value_pkg::AVERAGE_VALUE_IDLE);
	// a done pulse outside a burst is dropped here
	assign sample_in = conv_done && (state_r == average_value_pkg::AVERAGE_VALUE_SAMPLE);
	assign burst_end = (state_r == average_value_pkg::AVERAGE_VALUE_DONE);

	// burst sequencer: launch bit, sample count and converter requests
	always_comb begin
		state_nxt  = state_r;
		launch_nxt = launch_r;
		left_nxt   = left_r;
		size_nxt   = size_r;
		start_nxt  = 1'b0;
		route_nxt  = route_r;
		case (state_r)
			average_value_pkg::AVERAGE_VALUE_IDLE: begin
				if (launch_go) begin
					launch_nxt = 1'b1;
					size_nxt   = size_cfg;
					left_nxt   = burst_last(size_cfg);
					route_nxt  = chan_decode(chan_cfg);
					start_nxt  = 1'b1;
					state_nxt  = average_value_pkg::AVERAGE_VALUE_SAMPLE;
				end
			end
			average_value_pkg::AVERAGE_VALUE_SAMPLE: begin
				if (sample_in) begin
					if (left_r == 8'h00) begin
						state_nxt = average_value_pkg::AVERAGE_VALUE_DONE;
					end else begin
						left_nxt  = left_r - 8'h01;
						start_nxt = 1'b1;
					end
				end
			end
			average_value_pkg::AVERAGE_VALUE_DONE: begin
				// launch falls in the same cycle the results load
				launch_nxt = 1'b0;
				route_nxt  = 5'h00;
				state_nxt  = average_value_pkg::AVERAGE_VALUE_IDLE;
			end
			default: begin
				state_nxt = average_value_pkg::AVERAGE_VALUE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r  <= average_value_pkg::AVERAGE_VALUE_IDLE;
			launch_r <= 1'b0;
			left_r   <= 8'h00;
			size_r   <= 3'h0;
			start_r  <= 1'b0;
			route_r  <= 5'h00;
		end else begin
			state_r  <= state_nxt;
			launch_r <= launch_nxt;
			left_r   <= left_nxt;
			size_r   <= size_nxt;
			start_r  <= start_nxt;
			route_r  <= route_nxt;
		end
	end

	// running sum and extremes of the burst in flight
	always_comb begin
		sum_nxt     = sum_r;
		run_min_nxt = run_min_r;
		run_max_nxt = run_max_r;
		if (launch_go) begin
			sum_nxt     = 15'h0000;
			run_min_nxt = `AVERAGE_VALUE_MIN_INIT;
			run_max_nxt = `AVERAGE_VALUE_MAX_INIT;
		end else if (sample_in) begin
			// 15 bits hold 128 full-scale samples without wrap
			sum_nxt = sum_r + {7'h00, conv_data};
			if (conv_data < run_min_r) begin
				run_min_nxt = conv_data;
			end
			if (conv_data > run_max_r) begin
				run_max_nxt = conv_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sum_r     <= 15'h0000;
			run_min_r <= `AVERAGE_VALUE_MIN_INIT;
			run_max_r <= `AVERAGE_VALUE_MAX_INIT;
		end else begin
			sum_r     <= sum_nxt;
			run_min_r <= run_min_nxt;
			run_max_r <= run_max_nxt;
		end
	end

	// results move only at burst end: no write decodes their offsets
	always_comb begin
		avg_nxt = avg_r;
		min_nxt = min_r;
		max_nxt = max_r;
		if (burst_end) begin
			// truncating divide by 2^N keeps the datapath shift-only
			avg_nxt = 8'(sum_r >> size_r);
			min_nxt = run_min_r;
			max_nxt = run_max_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			avg_r <= `AVERAGE_VALUE_RESULT_RST;
			min_r <= `AVERAGE_VALUE_RESULT_RST;
			max_r <= `AVERAGE_VALUE_RESULT_RST;
		end else begin
			avg_r <= avg_nxt;
			min_r <= min_nxt;
			max_r <= max_nxt;
		end
	end

	// software-visible config and registered read data
	always_comb begin
		config_nxt = config_r;
		rdata_nxt  = rdata_r;
		if (config_wr) begin
			config_nxt = reg_wdata[`AVERAGE_VALUE_SIZE_MSB:`AVERAGE_VALUE_CHAN_LSB];
		end
		if (reg_rd) begin
			case (reg_addr)
				`AVERAGE_VALUE_OFS_LAUNCH:  rdata_nxt = {7'h00, launch_r};
				`AVERAGE_VALUE_OFS_CONFIG:  rdata_nxt = {2'b00, config_r};
				`AVERAGE_VALUE_OFS_AVERAGE: rdata_nxt = avg_r;
				`AVERAGE_VALUE_OFS_MINIMUM: rdata_nxt = min_r;
				`AVERAGE_VALUE_OFS_MAXIMUM: rdata_nxt = max_r;
				default:             rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			config_r <= `AVERAGE_VALUE_CONFIG_RST;
			rdata_r  <= 8'h00;
		end else begin
			config_r <= config_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign reg_rdata  = rdata_r;
	assign conv_start = start_r;
	assign chan_route = route_r;

endmodule : average_value_ctrl
`default_nettype wire

//--- rtl/average_value_map.svh
// register offsets, field positions and reset values of the converter control block
`ifndef AVERAGE_VALUE_MAP_SVH
`define AVERAGE_VALUE_MAP_SVH

`define AVERAGE_VALUE_OFS_LAUNCH   8'h50
`define AVERAGE_VALUE_OFS_CONFIG   8'h51
`define AVERAGE_VALUE_OFS_AVERAGE  8'h53
`define AVERAGE_VALUE_OFS_MINIMUM  8'h54
`define AVERAGE_VALUE_OFS_MAXIMUM  8'h55

`define AVERAGE_VALUE_LAUNCH_BIT   0
`define AVERAGE_VALUE_SIZE_MSB     5
`define AVERAGE_VALUE_SIZE_LSB     3
`define AVERAGE_VALUE_CHAN_MSB     2
`define AVERAGE_VALUE_CHAN_LSB     0

`define AVERAGE_VALUE_CONFIG_RST   6'h00
`define AVERAGE_VALUE_RESULT_RST   8'h00
`define AVERAGE_VALUE_MIN_INIT     8'hff
`define AVERAGE_VALUE_MAX_INIT     8'h00

`endif

//--- rtl/average_value_pkg.sv
// types of the converter control block
`default_nettype none
package average_value_pkg;

	typedef enum logic [2:0] {
		AVERAGE_VALUE_IDLE   = 3'b001,
		AVERAGE_VALUE_SAMPLE = 3'b010,
		AVERAGE_VALUE_DONE   = 3'b100
	} average_value_state_t;

	typedef enum logic [2:0] {
		AVERAGE_VALUE_CH_HAPTIC  = 3'h0,
		AVERAGE_VALUE_CH_MONITOR = 3'h1,
		AVERAGE_VALUE_CH_CHARGER = 3'h3,
		AVERAGE_VALUE_CH_PUMP    = 3'h4,
		AVERAGE_VALUE_CH_BOOST   = 3'h5
	} average_value_chan_t;

endpackage : average_value_pkg
`default_nettype wire

//--- tb/average_value_ctrl_tb.sv
// self-checking bench of the converter control block
`default_nettype none
module average_value_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = '0, rst = 1'h1, reg_wr = '0, reg_rd = '0, conv_done = '0, conv_start;
	logic [7:0] reg_addr = '0, reg_wdata = '0, conv_data = '0, reg_rdata;
	logic [4:0] chan_route;
	int         error_cnt = 0, n_checks = 0, cyc = 0;
	average_value_ctrl u_dut (
		.clk        (clk),
		.rst        (rst),
		.reg_wr     (reg_wr),
		.reg_rd     (reg_rd),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.reg_rdata  (reg_rdata),
		.conv_start (conv_start),
		.chan_route (chan_route),
		.conv_done  (conv_done),
		.conv_data  (conv_data)
	);
	always #5 clk = ~clk;
	// ceiling well above the 263 samples plus register traffic
	always @(posedge clk) if (++cyc == 20000) begin
		error_cnt++;
		print_verdict();
	end
	task automatic print_verdict();
		if (error_cnt == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
		@(posedge clk) reg_wr <= '0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
		@(posedge clk) {reg_rd, reg_addr} <= {1'h1, a};
		@(posedge clk) reg_rd <= '0;
		@(negedge clk) chk(what, exp, reg_rdata);
	endtask : rd
	// channel code doubles as size code, so code 7 runs 128 samples
	task automatic burst(logic [2:0] c);
		logic [15:0] sum;
		logic [7:0]  s, mn, mx;
		logic [4:0]  r;
		sum = '0;
		mn = 8'hff;
		mx = '0;
		r = (c == 3'h2 || c > 3'h5) ? 5'h00 : 5'h01 << (c - 3'(c > 3'h2));
		wr(8'h51, {2'h0, c, c});
		rd(8'h51, {2'h0, c, c}, "config");
		wr(8'h50, 8'h01);
		for (int k = 0; k < (1 << c); k++) begin
			s = 8'(k * 29 + c * 53 + 7);
			sum += 16'(s);
			if (s < mn) mn = s;
			if (s > mx) mx = s;
			@(negedge clk) chk("start", 8'h01, {7'h00, conv_start});
			chk("route", 8'(r), 8'(chan_route));
			if (k == 0) begin
				rd(8'h50, 8'h01, "busy");
				// a burst in flight ignores new config and a second launch
				wr(8'h51, 8'h3f);
				wr(8'h50, 8'h01);
				@(negedge clk) chk("no restart", 8'h00, {7'h00, conv_start});
				rd(8'h51, {2'h0, c, c}, "busy config");
			end
			@(posedge clk) {conv_done, conv_data} <= {1'h1, s};
			@(posedge clk) conv_done <= '0;
		end
		rd(8'h50, 8'h00, "launch");
		rd(8'h53, 8'(sum >> c), "average");
		rd(8'h54, mn, "minimum");
		rd(8'h55, mx, "maximum");
		wr(8'h54, ~mn);
		rd(8'h54, mn, "ro minimum");
	endtask : burst
	// idle values straight after power-up reset
	task automatic reset_values();
		@(negedge clk) chk("idle route", 8'h00, {3'h0, chan_route});
		rd(8'h50, 8'h00, "idle launch");
		rd(8'h53, 8'h00, "reset average");
		rd(8'h52, 8'h00, "unmapped");
	endtask : reset_values
	// reset in mid-burst must drop the launch bit, the config and every result
	task automatic reset_mid_burst();
		wr(8'h51, 8'h08);
		wr(8'h50, 8'h01);
		@(negedge clk) chk("mid start", 8'h01, {7'h00, conv_start});
		@(posedge clk) rst <= 1'h1;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk) chk("mid route", 8'h00, {3'h0, chan_route});
		rd(8'h50, 8'h00, "mid launch");
		rd(8'h51, 8'h00, "mid config");
		rd(8'h53, 8'h00, "mid average");
		rd(8'h54, 8'h00, "mid minimum");
		rd(8'h55, 8'h00, "mid maximum");
	endtask : reset_mid_burst
	initial begin
		repeat (3) @(posedge clk);
		rst <= '0;
		reset_values();
		for (int c = 0; c < 8; c++) burst(3'(c));
		reset_mid_burst();
		burst(3'h3);
		print_verdict();
	end
endmodule : average_value_ctrl_tb
bind average_value_ctrl average_value_properties u_chk (
	.clk        (clk),
	.rst        (rst),
	.reg_wr     (reg_wr),
	.reg_rd     (reg_rd),
	.reg_addr   (reg_addr),
	.reg_wdata  (reg_wdata),
	.reg_rdata  (reg_rdata),
	.conv_start (conv_start),
	.chan_route (chan_route),
	.conv_done  (conv_done),
	.conv_data  (conv_data)
);
`default_nettype wire

//--- tb/average_value_properties.sv
// port assertions of the converter control block
`default_nettype none
module average_value_properties (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       conv_start,
	input wire logic [4:0] chan_route,
	input wire logic       conv_done,
	input wire logic [7:0] conv_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_START_CAUSE: assert property (
		conv_start |-> $past(reg_wr && reg_addr == 8'h50 && reg_wdata[0]) || $past(conv_done))
		else $error("start without cause");
	AST_ROUTE_RISE: assert property ($rose(|chan_route) |-> conv_start)
		else $error("route without start");
	AST_START_PULSE: assert property (conv_start |=> !conv_start)
		else $error("start wider than one cycle");
	AST_DONE_NEXT: assert property (
		conv_done |-> ##1 conv_start or ##2 (chan_route == 5'h00)) else $error("no follow-up");
	AST_ROUTE_HOT: assert property ($onehot0(chan_route))
		else $error("route not one-hot");
	AST_ROUTE_HOLD: assert property (conv_done |-> $stable(chan_route))
		else $error("route moved in burst");
	AST_LAUNCH_BITS: assert property (
		reg_rd && reg_addr == 8'h50 |=> reg_rdata[7:1] == 7'h00) else $error("launch high bits");
	AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved");
	cover property (conv_done ##2 (chan_route == 5'h00));
	cover property (conv_start ##2 conv_start);
	cover property (reg_rd && reg_addr == 8'h55);
endmodule : average_value_properties
`default_nettype wire
